// ===== pkg/lqm_pkg.sv
// constants for the link quality and variance register block
package lqm_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int SUM_W = 32;
    localparam int WARN_W = 10;

    // register offsets
    localparam logic [4:0] VAR_CTRL_OFS = 5'h1A;
    localparam logic [4:0] VAR_DATA_OFS = 5'h1B;
    localparam logic [4:0] AUTO_CTRL_OFS = 5'h1C;
    localparam logic [4:0] LQM_CTRL_OFS = 5'h1D;
    localparam logic [4:0] IRQ_STAT_OFS = 5'h1E;
    localparam logic [4:0] IRQ_MASK_OFS = 5'h1F;

    // variance control fields
    localparam int VAR_READY_BIT = 15;
    localparam int VAR_HOLD_BIT = 3;

    // quality monitor control fields
    localparam int MON_ON_BIT = 15;
    localparam int FC_HI_BIT = 9;
    localparam int FC_LO_BIT = 8;
    localparam int FO_HI_BIT = 7;
    localparam int FO_LO_BIT = 6;
    localparam int BW_HI_BIT = 5;
    localparam int BW_LO_BIT = 4;
    localparam int GC_HI_BIT = 3;
    localparam int GC_LO_BIT = 2;
    localparam int EQ_HI_BIT = 1;
    localparam int EQ_LO_BIT = 0;

    // auto reset control field
    localparam int AUTO_RST_BIT = 0;

    // interrupt status and mask fields
    localparam int IRQ_QUAL_BIT = 0;
    localparam int IRQ_VAR_BIT = 1;
    localparam int IRQ_W = 2;

    // values after reset
    localparam logic [DATA_W-1:0] RD_RESET = 16'h0000;
    localparam logic [SUM_W-1:0] SUM_RESET = 32'h0000_0000;
    localparam logic [WARN_W-1:0] WARN_RESET = 10'h000;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
endpackage

// ===== verilog/link_quality_monitor_regs.sv
// register block for variance readout and link quality monitor
//
// Overview of operation
// - 32-bit sum valid only while ready set
// - first read low half, second high
// - ready clears after two data reads
// - hold clears after two data reads
// - monitor works only with 100 Mb link
// - violation raises interrupt when mask enables
// - control read clears warnings, re-arms interrupt
// - bits 9/8 frequency control high/low
// - bits 7/6 frequency offset high/low
// - bits 5/4 baseline wander high/low
// - bits 3/2 gain control high/low
// - bits 1/0 equalizer coefficient high/low
// - bits 14:10 ignore writes, read zero
// - optional automatic 100 Mb link reset
`timescale 1ns/1ns
module link_quality_monitor_regs
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [lqm_pkg::ADDR_W-1:0] ADDR,
    input wire logic [lqm_pkg::DATA_W-1:0] WR_DATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [lqm_pkg::DATA_W-1:0] RD_DATA,
    input wire logic [lqm_pkg::SUM_W-1:0] VAR_SUM_IN,
    input wire logic VAR_SUM_LOAD,
    input wire logic LINK_100_UP,
    input wire logic [lqm_pkg::WARN_W-1:0] THRESH_VIOLATION,
    output logic LINK_100_RESET,
    output logic MONITOR_ACTIVE,
    output logic IRQ
);
    import lqm_pkg::*;

    // all clocked state of the block except the two reset synchronizer flops
    typedef struct packed {
        logic [DATA_W-1:0] rd_data;
        logic [SUM_W-1:0] var_sum;
        logic var_ready;
        logic var_hold;
        logic read_high;
        logic monitor_on;
        logic [WARN_W-1:0] warn;
        logic irq_armed;
        logic auto_reset_on;
        logic link_reset;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
    } state_type;

    state_type st_r;
    state_type st_nxt;

    logic rst_meta_r;
    logic rst_sync_n_r;

    logic wr_var_ctrl;
    logic wr_auto_ctrl;
    logic wr_lqm_ctrl;
    logic wr_irq_stat;
    logic wr_irq_mask;
    logic rd_var_data;
    logic rd_lqm_ctrl;
    logic active;
    logic [WARN_W-1:0] warn_set;
    logic [WARN_W-1:0] warn_new;
    logic [IRQ_W-1:0] irq_event;
    logic [DATA_W-1:0] var_ctrl_view;
    logic [DATA_W-1:0] lqm_ctrl_view;
    logic [DATA_W-1:0] rd_mux;

    // reset release through two flops
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_n_r <= rst_meta_r;
        end
    end

    // address decode of the strobes
    assign wr_var_ctrl = WR_EN && (ADDR == VAR_CTRL_OFS);
    assign wr_auto_ctrl = WR_EN && (ADDR == AUTO_CTRL_OFS);
    assign wr_lqm_ctrl = WR_EN && (ADDR == LQM_CTRL_OFS);
    assign wr_irq_stat = WR_EN && (ADDR == IRQ_STAT_OFS);
    assign wr_irq_mask = WR_EN && (ADDR == IRQ_MASK_OFS);
    assign rd_var_data = RD_EN && (ADDR == VAR_DATA_OFS);
    assign rd_lqm_ctrl = RD_EN && (ADDR == LQM_CTRL_OFS);

    // monitor qualified by a valid 100 Mb link
    assign active = st_r.monitor_on && LINK_100_UP;

    // comparators report violations; thresholds at the extremes never fire
    assign warn_set = active ? THRESH_VIOLATION : WARN_RESET;

    // warnings that become set this cycle
    assign warn_new = warn_set & ~st_r.warn;

    // interrupt source events
    always_comb
    begin
        irq_event = IRQ_RESET;
        irq_event[IRQ_QUAL_BIT] = st_r.irq_armed && (|warn_set);
        irq_event[IRQ_VAR_BIT] = VAR_SUM_LOAD && !st_r.var_hold;
    end

    // readable view of the variance control register
    always_comb
    begin
        var_ctrl_view = RD_RESET;
        var_ctrl_view[VAR_READY_BIT] = st_r.var_ready;
        var_ctrl_view[VAR_HOLD_BIT] = st_r.var_hold;
    end

    // readable view of the monitor control register
    always_comb
    begin
        lqm_ctrl_view = RD_RESET;
        lqm_ctrl_view[MON_ON_BIT] = st_r.monitor_on;
        lqm_ctrl_view[FC_HI_BIT] = st_r.warn[FC_HI_BIT];
        lqm_ctrl_view[FC_LO_BIT] = st_r.warn[FC_LO_BIT];
        lqm_ctrl_view[FO_HI_BIT] = st_r.warn[FO_HI_BIT];
        lqm_ctrl_view[FO_LO_BIT] = st_r.warn[FO_LO_BIT];
        lqm_ctrl_view[BW_HI_BIT] = st_r.warn[BW_HI_BIT];
        lqm_ctrl_view[BW_LO_BIT] = st_r.warn[BW_LO_BIT];
        lqm_ctrl_view[GC_HI_BIT] = st_r.warn[GC_HI_BIT];
        lqm_ctrl_view[GC_LO_BIT] = st_r.warn[GC_LO_BIT];
        lqm_ctrl_view[EQ_HI_BIT] = st_r.warn[EQ_HI_BIT];
        lqm_ctrl_view[EQ_LO_BIT] = st_r.warn[EQ_LO_BIT];
    end

    // read data selection; unmapped offsets read zero
    always_comb
    begin
        rd_mux = RD_RESET;
        unique case (ADDR)
            VAR_CTRL_OFS:
            begin
                rd_mux = var_ctrl_view;
            end
            VAR_DATA_OFS:
            begin
                // low half first, high half on the second read
                rd_mux = st_r.read_high ? st_r.var_sum[31:16]
                                        : st_r.var_sum[15:0];
            end
            AUTO_CTRL_OFS:
            begin
                rd_mux[AUTO_RST_BIT] = st_r.auto_reset_on;
            end
            LQM_CTRL_OFS:
            begin
                rd_mux = lqm_ctrl_view;
            end
            IRQ_STAT_OFS:
            begin
                rd_mux[IRQ_W-1:0] = st_r.irq_stat;
            end
            IRQ_MASK_OFS:
            begin
                rd_mux[IRQ_W-1:0] = st_r.irq_mask;
            end
            default:
            begin
                rd_mux = RD_RESET;
            end
        endcase
    end

    // next state of the whole block
    always_comb
    begin
        st_nxt = st_r;

        // read data stands only in the cycle after the read strobe
        st_nxt.rd_data = RD_EN ? rd_mux : RD_RESET;

        // new sum loads only while not held
        if (VAR_SUM_LOAD && !st_r.var_hold)
        begin
            st_nxt.var_sum = VAR_SUM_IN;
            st_nxt.var_ready = 1'b1;
            st_nxt.read_high = 1'b0;
        end

        // variance control write: only the hold bit is writable
        if (wr_var_ctrl)
        begin
            st_nxt.var_hold = WR_DATA[VAR_HOLD_BIT];
            st_nxt.read_high = 1'b0;
        end

        // two consecutive data reads release ready and hold
        if (rd_var_data)
        begin
            if (st_r.read_high)
            begin
                st_nxt.read_high = 1'b0;
                st_nxt.var_ready = 1'b0;
                st_nxt.var_hold = 1'b0;
            end
            else
            begin
                st_nxt.read_high = 1'b1;
            end
        end

        // monitor enable; other written bits are dropped
        if (wr_lqm_ctrl)
        begin
            st_nxt.monitor_on = WR_DATA[MON_ON_BIT];
        end

        // sticky warnings; a read clears but a new violation wins
        if (rd_lqm_ctrl)
        begin
            st_nxt.warn = warn_set;
            st_nxt.irq_armed = 1'b1;
        end
        else
        begin
            st_nxt.warn = st_r.warn | warn_set;
        end

        // one interrupt per violation until the control read re-arms
        if (irq_event[IRQ_QUAL_BIT] && !rd_lqm_ctrl)
        begin
            st_nxt.irq_armed = 1'b0;
        end

        // auto reset option
        if (wr_auto_ctrl)
        begin
            st_nxt.auto_reset_on = WR_DATA[AUTO_RST_BIT];
        end

        // one-cycle 100 Mb link reset on a fresh warning
        st_nxt.link_reset = st_r.auto_reset_on && (|warn_new);

        // interrupt mask
        if (wr_irq_mask)
        begin
            st_nxt.irq_mask = WR_DATA[IRQ_W-1:0];
        end

        // status: write one to clear, new event wins
        st_nxt.irq_stat = st_r.irq_stat;
        if (wr_irq_stat)
        begin
            st_nxt.irq_stat = st_r.irq_stat & ~WR_DATA[IRQ_W-1:0];
        end
        st_nxt.irq_stat = st_nxt.irq_stat | irq_event;
    end

    // state register
    always_ff @(posedge CORE_CLK or negedge rst_sync_n_r)
    begin
        if (!rst_sync_n_r)
        begin
            st_r.rd_data <= RD_RESET;
            st_r.var_sum <= SUM_RESET;
            st_r.var_ready <= 1'b0;
            st_r.var_hold <= 1'b0;
            st_r.read_high <= 1'b0;
            st_r.monitor_on <= 1'b0;
            st_r.warn <= WARN_RESET;
            st_r.irq_armed <= 1'b1;
            st_r.auto_reset_on <= 1'b0;
            st_r.link_reset <= 1'b0;
            st_r.irq_stat <= IRQ_RESET;
            st_r.irq_mask <= IRQ_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs
    assign RD_DATA = st_r.rd_data;
    assign LINK_100_RESET = st_r.link_reset;
    assign MONITOR_ACTIVE = active;
    assign IRQ = |(st_r.irq_stat & st_r.irq_mask);

endmodule // link_quality_monitor_regs

// ===== tb/lqm_regs_monitor.sv
// assertion checker for the link quality register block
`timescale 1ns/1ns
module lqm_regs_monitor
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [lqm_pkg::ADDR_W-1:0] ADDR,
    input wire logic [lqm_pkg::DATA_W-1:0] WR_DATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [lqm_pkg::DATA_W-1:0] RD_DATA,
    input wire logic VAR_SUM_LOAD,
    input wire logic [lqm_pkg::WARN_W-1:0] THRESH_VIOLATION,
    input wire logic LINK_100_UP,
    input wire logic LINK_100_RESET,
    input wire logic MONITOR_ACTIVE,
    input wire logic IRQ
);
    import lqm_pkg::*;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // strobes decoded per register
    wire rd_lq = RD_EN && ADDR == LQM_CTRL_OFS;
    wire rd_vd = RD_EN && ADDR == VAR_DATA_OFS && !VAR_SUM_LOAD;
    wire rd_vc = RD_EN && ADDR == VAR_CTRL_OFS;
    wire hit = MONITOR_ACTIVE && |THRESH_VIOLATION;
    // phase reset, two data reads, then control read
    sequence s_var_pair;
        WR_EN && ADDR == VAR_CTRL_OFS && !VAR_SUM_LOAD ##1 rd_vd
        ##1 rd_vd ##1 rd_vc;
    endsequence
    sequence s_lq_twice;
        !MONITOR_ACTIVE && rd_lq ##1 !MONITOR_ACTIVE && rd_lq;
    endsequence
    a_rd_quiet_zero: assert property (!$past(RD_EN)
        |-> RD_DATA == 16'h0000)
        else $error("read data not zero outside read cycle");
    a_mon_needs_link: assert property (MONITOR_ACTIVE |-> LINK_100_UP)
        else $error("monitor active without link");
    a_rsvd_zero: assert property ($past(rd_lq)
        |-> RD_DATA[14:10] == 5'h00)
        else $error("reserved control bits not zero");
    a_warn_capture: assert property (MONITOR_ACTIVE ##1 rd_lq |=>
        (RD_DATA[9:0] & $past(THRESH_VIOLATION, 2))
        == $past(THRESH_VIOLATION, 2))
        else $error("warning bit missing on read");
    a_read_clears: assert property (s_lq_twice
        |=> RD_DATA[9:0] == 10'h000)
        else $error("warnings survive control read");
    a_var_pair_clear: assert property (s_var_pair |=>
        !RD_DATA[VAR_READY_BIT] && !RD_DATA[VAR_HOLD_BIT])
        else $error("ready or hold left after two reads");
    a_irq_no_cause: assert property (!hit && !VAR_SUM_LOAD && !WR_EN
        |=> $stable(IRQ))
        else $error("interrupt moved without cause");
    a_reset_cause: assert property (LINK_100_RESET |-> $past(hit))
        else $error("link reset without violation");
    // a different fresh violation next cycle may legally extend the pulse
    a_reset_pulse: assert property (LINK_100_RESET
        && $stable(THRESH_VIOLATION) |=> !LINK_100_RESET)
        else $error("link reset longer than one cycle");
endmodule // lqm_regs_monitor

bind link_quality_monitor_regs lqm_regs_monitor u_lqm_regs_monitor
(
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
    .VAR_SUM_LOAD(VAR_SUM_LOAD), .THRESH_VIOLATION(THRESH_VIOLATION),
    .LINK_100_UP(LINK_100_UP), .LINK_100_RESET(LINK_100_RESET),
    .MONITOR_ACTIVE(MONITOR_ACTIVE), .IRQ(IRQ)
);

// ===== tb/link_quality_monitor_regs_tb_top.sv
// self-checking bench for the link quality register block
`timescale 1ns/1ns
module link_quality_monitor_regs_tb_top;
    import lqm_pkg::*;
    logic CORE_CLK = 1'b0, RST_N = 1'b0, WR_EN = 1'b0, RD_EN = 1'b0;
    logic VAR_SUM_LOAD = 1'b0, LINK_100_UP = 1'b0;
    logic [4:0] ADDR = 5'h00;
    logic [15:0] WR_DATA = 16'h0000;
    logic [31:0] VAR_SUM_IN = 32'h0000_0000;
    logic [9:0] THRESH_VIOLATION = 10'h000;
    logic [15:0] RD_DATA;
    logic LINK_100_RESET, MONITOR_ACTIVE, IRQ;
    int errors = 0, check_count = 0;
    // 25 MHz core clock
    always #20 CORE_CLK = ~CORE_CLK;
    link_quality_monitor_regs u_link_quality_monitor_regs
    (
        .CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .WR_DATA(WR_DATA),
        .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
        .VAR_SUM_IN(VAR_SUM_IN), .VAR_SUM_LOAD(VAR_SUM_LOAD),
        .LINK_100_UP(LINK_100_UP), .THRESH_VIOLATION(THRESH_VIOLATION),
        .LINK_100_RESET(LINK_100_RESET), .MONITOR_ACTIVE(MONITOR_ACTIVE),
        .IRQ(IRQ)
    );
    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle bus strobes, each ends just after the taking edge
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        ADDR <= a;
        WR_DATA <= d;
        WR_EN <= 1'b1;
        @(posedge CORE_CLK);
        WR_EN <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        ADDR <= a;
        RD_EN <= 1'b1;
        @(posedge CORE_CLK);
        RD_EN <= 1'b0;
        #1;
        chk(RD_DATA, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge CORE_CLK);
        #1;
    endtask
    task automatic viol(input logic [9:0] v);
        THRESH_VIOLATION <= v;
        idle(1);
        THRESH_VIOLATION <= 10'h000;
    endtask
    task automatic load(input logic [31:0] s);
        VAR_SUM_IN <= s;
        VAR_SUM_LOAD <= 1'b1;
        idle(1);
        VAR_SUM_LOAD <= 1'b0;
    endtask
    // reset values, unmapped read, reserved bits
    task automatic t_reset;
        rd(VAR_CTRL_OFS, 16'h0000);
        rd(VAR_DATA_OFS, 16'h0000);
        rd(LQM_CTRL_OFS, 16'h0000);
        rd(5'h00, 16'h0000);
        wr(LQM_CTRL_OFS, 16'hFFFF);
        rd(LQM_CTRL_OFS, 16'h8000);
    endtask
    // held sum read as two halves, second load blocked
    task automatic t_var;
        load(32'hA5C3_1E7F);
        rd(VAR_CTRL_OFS, 16'h8000);
        wr(VAR_CTRL_OFS, 16'h0008);
        load(32'h1234_5678);
        wr(VAR_CTRL_OFS, 16'h0008);
        rd(VAR_DATA_OFS, 16'h1E7F);
        rd(VAR_DATA_OFS, 16'hA5C3);
        rd(VAR_CTRL_OFS, 16'h0000);
        rd(IRQ_STAT_OFS, 16'h0002);
        wr(IRQ_STAT_OFS, 16'h0002);
    endtask
    // no link means no monitoring
    task automatic t_gate;
        viol(10'h3FF);
        rd(LQM_CTRL_OFS, 16'h8000);
        rd(LQM_CTRL_OFS, 16'h8000);
        LINK_100_UP <= 1'b1;
        idle(1);
        chk({15'h0000, MONITOR_ACTIVE}, 16'h0001);
    endtask
    // every warning bit, interrupt, re-arm and mask
    task automatic t_warn;
        wr(IRQ_MASK_OFS, 16'h0001);
        rd(IRQ_MASK_OFS, 16'h0001);
        for (int i = 0; i < 10; i++)
        begin
            viol(10'h001 << i);
            chk({15'h0000, IRQ}, 16'h0001);
            idle(i % 3);
            rd(LQM_CTRL_OFS, 16'h8000 | (16'h0001 << i));
            rd(LQM_CTRL_OFS, 16'h8000);
            wr(IRQ_STAT_OFS, 16'h0001);
            chk({15'h0000, IRQ}, 16'h0000);
        end
        viol(10'h001);
        wr(IRQ_STAT_OFS, 16'h0001);
        viol(10'h002);
        chk({15'h0000, IRQ}, 16'h0000);
        rd(LQM_CTRL_OFS, 16'h8003);
        wr(IRQ_MASK_OFS, 16'h0000);
        viol(10'h004);
        chk({15'h0000, LINK_100_RESET}, 16'h0000);
        chk({15'h0000, IRQ}, 16'h0000);
        rd(IRQ_STAT_OFS, 16'h0001);
    endtask
    // automatic link reset fires once per new warning
    task automatic t_auto;
        int n;
        n = 0;
        wr(AUTO_CTRL_OFS, 16'h0001);
        rd(AUTO_CTRL_OFS, 16'h0001);
        rd(LQM_CTRL_OFS, 16'h8004);
        THRESH_VIOLATION <= 10'h020;
        repeat (4)
        begin
            idle(1);
            if (LINK_100_RESET === 1'b1)
                n++;
        end
        THRESH_VIOLATION <= 10'h000;
        chk(n[15:0], 16'h0001);
    endtask
    task automatic tally_and_finish;
        if (errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // reset, then scenarios
    initial
    begin
        repeat (6) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        idle(3);
        t_reset();
        t_var();
        t_gate();
        t_warn();
        t_auto();
        tally_and_finish();
    end
endmodule // link_quality_monitor_regs_tb_top
